// file: hdl/sequencer_pkg.sv
package sequencer_pkg;
    localparam int         MAX_STATES    = 20;
    localparam int         COUNT_W       = 5;
    localparam int         IDX_W         = 5;
    localparam int         CODE_W        = 8;
    localparam int         EVENT_SRC_W   = 32;
    localparam int         ACTION_W      = 32;
    localparam logic [IDX_W-1:0]  FIRST_INDEX = 5'h00;
    localparam logic [IDX_W-1:0]  INDEX_STEP  = 5'h01;
    localparam logic [COUNT_W-1:0] ZERO_PAIRS = 5'h00;
    localparam logic [COUNT_W-1:0] MAX_PAIRS  = 5'h14;
    // event selection codes
    localparam logic [CODE_W-1:0] EV_FALSE       = 8'h00;
    localparam logic [CODE_W-1:0] EV_TRUE        = 8'h01;
    localparam logic [CODE_W-1:0] EV_ON_REF      = 8'h04;
    localparam logic [CODE_W-1:0] EV_TIMER0_DONE = 8'h1E;
    // action selection codes
    localparam logic [CODE_W-1:0] ACT_NONE       = 8'h01;
    localparam logic [CODE_W-1:0] ACT_PRESET0    = 8'h0A;
    localparam logic [CODE_W-1:0] ACT_PRESET1    = 8'h0B;
    localparam logic [CODE_W-1:0] ACT_TIMER0     = 8'h1D;
    localparam logic [CODE_W-1:0] CODE_ZERO      = 8'h00;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} seq_state_type;
endpackage

// file: hdl/event_selector.sv
`timescale 1ns/1ps
module event_selector
    import sequencer_pkg::*;
(
    input  wire logic [sequencer_pkg::CODE_W-1:0]      code,
    input  wire logic [sequencer_pkg::EVENT_SRC_W-1:0] sources,
    output wire logic                                  hit
);
    // codes beyond the source vector evaluate false
    assign hit = (code == EV_FALSE) ? 1'b0 :
                 (code == EV_TRUE)  ? 1'b1 :
                 (code < CODE_W'(EVENT_SRC_W)) ? sources[code[IDX_W-1:0]] : 1'b0;
endmodule

// file: hdl/event_action_sequencer.sv
`timescale 1ns/1ps
// Function
// - action n runs only after event n true
// - after action n, test event n+1
// - only the current state's event is tested
// - false event: no action, same state
// - start at state one
// - zero to twenty pairs programmable
// - after last pair, wrap to first
// - event and action arrays indexed by state
// - events from inside or external controller
// - runs only while enable is on
// - event codes false0 true1 onref4 timer30
// - action codes none1 preset10/11 timer29
module event_action_sequencer
    import sequencer_pkg::*;
(
    input  wire logic                                  MCLK,
    input  wire logic                                  NRST,
    input  wire logic                                  SCAN_TICK,
    input  wire logic                                  ENABLE,
    input  wire logic [sequencer_pkg::COUNT_W-1:0]     PAIR_COUNT,
    input  wire logic                                  CFG_WE,
    input  wire logic [sequencer_pkg::IDX_W-1:0]       CFG_INDEX,
    input  wire logic [sequencer_pkg::CODE_W-1:0]      CFG_EVENT,
    input  wire logic [sequencer_pkg::CODE_W-1:0]      CFG_ACTION,
    input  wire logic [sequencer_pkg::EVENT_SRC_W-1:0] INT_EVENTS,
    input  wire logic [sequencer_pkg::EVENT_SRC_W-1:0] EXT_EVENTS,
    output logic      [sequencer_pkg::ACTION_W-1:0]    ACTION_PULSE,
    output logic      [sequencer_pkg::CODE_W-1:0]      ACTION_CODE,
    output logic      [sequencer_pkg::IDX_W-1:0]       STATE_INDEX,
    output logic                                       RUNNING
);
    import sequencer_pkg::*;

    logic [CODE_W-1:0]      event_sel_r  [MAX_STATES];
    logic [CODE_W-1:0]      action_sel_r [MAX_STATES];
    logic [IDX_W-1:0]       index_r;
    logic [IDX_W-1:0]       index_nxt;
    seq_state_type          state_r;
    seq_state_type          state_nxt;
    logic [EVENT_SRC_W-1:0] ext_meta_r;
    logic [EVENT_SRC_W-1:0] ext_sync_r;
    logic [EVENT_SRC_W-1:0] sources;
    logic [COUNT_W-1:0]     pairs_clamped;
    logic                   active;
    logic                   event_hit;
    logic                   fire;
    logic                   last_pair;
    logic [CODE_W-1:0]      cur_event;
    logic [CODE_W-1:0]      cur_action;
    logic                   pulse_ok;
    logic [ACTION_W-1:0]    pulse_vec;

    // codes none and zero are bookkeeping only; codes past the pulse vector
    // still update the code output so software can see them
    function automatic logic action_pulses(input logic [CODE_W-1:0] code);
        return (code != ACT_NONE) && (code != CODE_ZERO) && (code < CODE_W'(ACTION_W));
    endfunction

    // external controller events arrive asynchronously
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ext_meta_r <= '0;
            ext_sync_r <= '0;
        end else begin
            ext_meta_r <= EXT_EVENTS;
            ext_sync_r <= ext_meta_r;
        end
    end

    assign sources       = INT_EVENTS | ext_sync_r;
    assign pairs_clamped = (PAIR_COUNT > MAX_PAIRS) ? MAX_PAIRS : PAIR_COUNT;
    assign active        = ENABLE && (pairs_clamped != ZERO_PAIRS);
    assign cur_event     = event_sel_r[index_r];
    assign cur_action    = action_sel_r[index_r];
    // >= so that shrinking the pair count below the index wraps on the next fire
    assign last_pair     = (index_r >= IDX_W'(pairs_clamped - IDX_W'(INDEX_STEP)));
    assign pulse_ok      = action_pulses(cur_action);

    event_selector u_event_selector (
        .code    (cur_event),
        .sources (sources),
        .hit     (event_hit)
    );

    // one evaluation per tick, only in the run state
    assign fire = (state_r == ST_RUN) && active && SCAN_TICK && event_hit;

    always_comb begin
        state_nxt = state_r;
        index_nxt = index_r;
        case (state_r)
            ST_IDLE: begin
                index_nxt = FIRST_INDEX;
                if (active) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!active) begin
                    state_nxt = ST_IDLE;
                    index_nxt = FIRST_INDEX;
                end else if (fire) begin
                    index_nxt = last_pair ? FIRST_INDEX : index_r + INDEX_STEP;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                index_nxt = FIRST_INDEX;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= ST_IDLE;
            index_r <= FIRST_INDEX;
        end else begin
            state_r <= state_nxt;
            index_r <= index_nxt;
        end
    end

    // configuration arrays; reset leaves every pair as false / no action
    genvar g;
    generate
        for (g = 0; g < MAX_STATES; g++) begin : g_cfg
            always_ff @(posedge MCLK or negedge NRST) begin
                if (!NRST) begin
                    event_sel_r[g]  <= EV_FALSE;
                    action_sel_r[g] <= ACT_NONE;
                end else if (CFG_WE && (CFG_INDEX == IDX_W'(g))) begin
                    event_sel_r[g]  <= CFG_EVENT;
                    action_sel_r[g] <= CFG_ACTION;
                end
            end
        end
    endgenerate

    // one-hot decode of the current action code
    generate
        for (g = 0; g < ACTION_W; g++) begin : g_pulse
            assign pulse_vec[g] = pulse_ok && (cur_action == CODE_W'(g));
        end
    endgenerate

    // action pulse: one bit per action code below 32, none and zero never pulse
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ACTION_PULSE <= '0;
            ACTION_CODE  <= CODE_ZERO;
        end else begin
            ACTION_PULSE <= '0;
            if (fire) begin
                ACTION_CODE  <= cur_action;
                ACTION_PULSE <= pulse_vec;
            end
        end
    end

    assign STATE_INDEX = index_r;
    assign RUNNING     = (state_r == ST_RUN);
endmodule

// file: dv/seq_monitor.sv
`timescale 1ns/1ps
module seq_monitor
    import sequencer_pkg::*;
(
    input wire logic                                MCLK,
    input wire logic                                NRST,
    input wire logic                                SCAN_TICK,
    input wire logic                                ENABLE,
    input wire logic [sequencer_pkg::COUNT_W-1:0]   PAIR_COUNT,
    input wire logic [sequencer_pkg::ACTION_W-1:0]  ACTION_PULSE,
    input wire logic [sequencer_pkg::CODE_W-1:0]    ACTION_CODE,
    input wire logic [sequencer_pkg::IDX_W-1:0]     STATE_INDEX,
    input wire logic                                RUNNING
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    fire_cause_a: assert property (ACTION_PULSE != 0 |-> $past(SCAN_TICK && RUNNING && ENABLE))
        else $error("pulse without tick");
    one_pulse_a: assert property ($onehot0(ACTION_PULSE))
        else $error("several pulses");
    pulse_code_a: assert property (ACTION_PULSE != 0 |-> ACTION_PULSE == 32'h1 << ACTION_CODE)
        else $error("pulse not code");
    index_step_a: assert property (RUNNING && $past(RUNNING) && $changed(STATE_INDEX)
        |-> STATE_INDEX == $past(STATE_INDEX) + 5'h01 || STATE_INDEX == 5'h00)
        else $error("bad index step");
    hold_index_a: assert property (!SCAN_TICK && ENABLE && PAIR_COUNT != 0 |=> $stable(STATE_INDEX))
        else $error("index moved");
    idle_clear_a: assert property (!(ENABLE && PAIR_COUNT != 0) |=> !RUNNING && STATE_INDEX == 0)
        else $error("not idle");
    run_entry_a: assert property (ENABLE && PAIR_COUNT != 0 |=> RUNNING)
        else $error("not running");
    start_first_a: assert property ($rose(RUNNING) |-> STATE_INDEX == 0)
        else $error("bad start");
endmodule
bind event_action_sequencer seq_monitor mon (.*);

// file: dv/drive_model.sv
`timescale 1ns/1ps
module drive_model (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic [31:0] ACTION_PULSE,
    output logic      [31:0] INT_EVENTS,
    output logic      [31:0] EXT_EVENTS
);
    logic       on_ref_r;
    logic [3:0] timer_r;
    // speed is at reference from the cycle after a preset0 pulse until the cycle after a preset1 pulse
    assign INT_EVENTS = {27'h0, on_ref_r, 4'h0};
    assign EXT_EVENTS = {1'b0, timer_r == 4'h1, 30'h0};
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            on_ref_r <= 1'b0;
            timer_r  <= 4'h0;
        end else begin
            if (ACTION_PULSE[10] || ACTION_PULSE[11]) on_ref_r <= ACTION_PULSE[10];
            if (ACTION_PULSE[29]) timer_r <= 4'h6;
            else if (timer_r > 4'h1) timer_r <= timer_r - 4'h1;
        end
    end
endmodule

// file: dv/event_action_sequencer_tb.sv
`timescale 1ns/1ps
module event_action_sequencer_tb;
    import sequencer_pkg::*;
    logic MCLK = 0, NRST = 0, SCAN_TICK = 0, ENABLE = 1, CFG_WE = 0, RUNNING;
    logic [4:0] PAIR_COUNT = 5'h04, CFG_INDEX = 5'h00, STATE_INDEX;
    logic [7:0] CFG_EVENT = 8'h00, CFG_ACTION = 8'h00, ACTION_CODE;
    logic [31:0] INT_EVENTS, EXT_EVENTS, ACTION_PULSE;
    int error_cnt = 0, tests_run = 0;
    always #20 MCLK = ~MCLK;
    event_action_sequencer uut (
        .MCLK         (MCLK),
        .NRST         (NRST),
        .SCAN_TICK    (SCAN_TICK),
        .ENABLE       (ENABLE),
        .PAIR_COUNT   (PAIR_COUNT),
        .CFG_WE       (CFG_WE),
        .CFG_INDEX    (CFG_INDEX),
        .CFG_EVENT    (CFG_EVENT),
        .CFG_ACTION   (CFG_ACTION),
        .INT_EVENTS   (INT_EVENTS),
        .EXT_EVENTS   (EXT_EVENTS),
        .ACTION_PULSE (ACTION_PULSE),
        .ACTION_CODE  (ACTION_CODE),
        .STATE_INDEX  (STATE_INDEX),
        .RUNNING      (RUNNING)
    );
    drive_model drv (.MCLK, .NRST, .ACTION_PULSE, .INT_EVENTS, .EXT_EVENTS);
    task chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task cfg(logic [4:0] i, logic [7:0] ev, logic [7:0] ac);
        @(negedge MCLK);
        {CFG_WE, CFG_INDEX, CFG_EVENT, CFG_ACTION} = {1'b1, i, ev, ac};
        @(negedge MCLK);
        CFG_WE = 0;
    endtask
    task step(logic [31:0] p, logic [7:0] c, logic [4:0] i);
        @(negedge MCLK);
        SCAN_TICK = 1;
        @(negedge MCLK);
        SCAN_TICK = 0;
        chk("pulse", ACTION_PULSE, p);
        chk("code", ACTION_CODE, c);
        chk("index", STATE_INDEX, i);
    endtask
    task s_app;
        cfg(0, EV_TRUE, ACT_PRESET0);
        cfg(1, EV_ON_REF, ACT_TIMER0);
        cfg(2, EV_TIMER0_DONE, ACT_PRESET1);
        cfg(3, EV_FALSE, ACT_NONE);
        step(32'h1 << ACT_PRESET0, ACT_PRESET0, 1);
        step(32'h1 << ACT_TIMER0, ACT_TIMER0, 2);
        step(0, ACT_TIMER0, 2);
        repeat (12) @(negedge MCLK);
        step(32'h1 << ACT_PRESET1, ACT_PRESET1, 3);
        step(0, ACT_PRESET1, 3);
    endtask
    task s_wrap;
        cfg(3, EV_TRUE, ACT_NONE);
        step(0, ACT_NONE, 0);
    endtask
    task s_off;
        step(32'h1 << ACT_PRESET0, ACT_PRESET0, 1);
        ENABLE = 0;
        step(0, ACT_PRESET0, 0);
        chk("run", RUNNING, 0);
        {ENABLE, PAIR_COUNT} = {1'b1, 5'h00};
        step(0, ACT_PRESET0, 0);
        PAIR_COUNT = 5'h04;
        step(32'h1 << ACT_PRESET0, ACT_PRESET0, 1);
    endtask
    task s_reset;
        NRST = 0;
        @(negedge MCLK);
        chk("index", STATE_INDEX, 0);
        chk("code", ACTION_CODE, 0);
        NRST = 1;
        @(negedge MCLK);
        chk("run", RUNNING, 1);
        step(0, CODE_ZERO, 0);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge MCLK);
        NRST = 1;
        s_app;
        s_wrap;
        s_off;
        s_reset;
        test_done;
    end
    initial begin
        repeat (3000) @(posedge MCLK);
        error_cnt++;
        test_done;
    end
endmodule
